/* hmc_pkg.sv */
// Package with offsets, reset values, timing constants and carrier types of the host misc bank.
// Notes on behaviour
// - Timer count reads in bits 15:0, upper bits zero, resets to FFFFh.
// - Timer runs while run bit is one; one-to-zero change presets preload FFFFh.
// - Timer loads from the 16-bit software preload value.
// - Transmit sends low half first; receive places low half first.
// - Half-order control matters only on the 16-bit host bus.
// - On 32-bit bus, upper data lines are high half, lower lines low half.
// - 16-bit, control not all ones: address bit one selects high half.
// - 16-bit, control all ones: address bit one selects low half.
// - Free 32-bit tick counter starts at zero and counts every clock.
// - Free tick counter wraps from maximum to zero and keeps going.
// - 16-bit reads of the free counter latch the whole count on first half.
// - Free tick counter never stops, whatever the power state.
// - Dropped-frame counter counts each discarded frame, resets to zero.
// - Any read of the dropped-frame counter returns it and clears it.
// - An event is raised when the dropped-frame counter steps 7FFFFFFFh to 80000000h.
`default_nettype none

package hmc_pkg;

  localparam logic [7:0] OFF_TIMER_PRESENT_COUNT = 8'h90;
  localparam logic [7:0] OFF_HOST_HALF_ORDER_CONTROL = 8'h98;
  localparam logic [7:0] OFF_FREE_TICK_COUNT = 8'h9C;
  localparam logic [7:0] OFF_DISCARDED_FRAME_TALLY = 8'hA0;

  localparam logic [15:0] TIMER_COUNT_RESET = 16'hFFFF;
  localparam logic [15:0] TIMER_PRELOAD_RESET = 16'hFFFF;
  localparam logic [31:0] HALF_ORDER_RESET = 32'h0000_0000;
  localparam logic [31:0] HALF_ORDER_SWAPPED = 32'hFFFF_FFFF;
  localparam logic [31:0] FREE_TICK_RESET = 32'h0000_0000;
  localparam logic [31:0] DISCARD_RESET = 32'h0000_0000;
  localparam logic [31:0] DISCARD_BELOW_MID = 32'h7FFF_FFFF;

  localparam int CLK_PERIOD_NS = 100;
  localparam int FREE_CLEAR_NS = 160;
  // Rounded up, so the wait always covers the whole clearing time.
  localparam int FREE_CLEAR_CYCLES =
    (FREE_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host pins as they arrive: strap, active-low strobes, address and write data.
  typedef struct packed {
    logic bus16;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [31:0] data;
  } hmc_pins_t;

  // Idle pin levels loaded into both synchroniser stages at reset.
  localparam hmc_pins_t PINS_IDLE = '{bus16: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                      addr: 8'h00, data: 32'h0000_0000};

  typedef struct packed {
    logic run;
    logic [15:0] preload;
    logic [15:0] count;
  } hmc_timer_state_t;

  typedef struct packed {
    hmc_pins_t sync1;
    hmc_pins_t sync2;
    logic rd_prev;
    logic wr_prev;
    logic [31:0] rd_data;
    logic [31:0] half_order;
    logic [31:0] free_tick;
    logic [31:0] free_latch;
    logic latch_valid;
    logic [31:0] discard;
    logic discard_mid;
    logic [15:0] tx_high;
    logic tx_pend;
    logic [15:0] tx_half;
    logic tx_half_valid;
    logic [15:0] rx_low;
    logic rx_have_low;
    logic [31:0] rx_word;
    logic rx_word_valid;
  } hmc_state_t;

endpackage

`default_nettype wire

/* hmc_gp_timer.sv */
// General purpose down-counting timer with preload and run control.
`default_nettype none

module hmc_gp_timer (
  input wire logic clk_i, // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic cfg_wr_i, // One-cycle pulse: configuration written.
  input wire logic cfg_run_i, // Run bit carried by the write.
  input wire logic [15:0] cfg_preload_i, // Preload value carried by the write.
  input wire logic tick_i, // One-cycle timer tick.
  output logic run_o, // Present run state.
  output logic [15:0] count_o // Present count.
);

  hmc_pkg::hmc_timer_state_t st;
  hmc_pkg::hmc_timer_state_t next_st;

  always_comb begin
    next_st = st;
    if (cfg_wr_i) begin
      next_st.run = cfg_run_i;
      if (st.run && !cfg_run_i) begin
        next_st.preload = hmc_pkg::TIMER_PRELOAD_RESET;
      end else begin
        next_st.preload = cfg_preload_i;
      end
      if (!st.run && cfg_run_i) begin
        next_st.count = cfg_preload_i;
      end
    end else if (st.run && tick_i) begin
      // The count restarts from the preload after reaching zero.
      if (st.count == 16'h0000) begin
        next_st.count = st.preload;
      end else begin
        next_st.count = st.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st.run <= 1'b0;
      st.preload <= hmc_pkg::TIMER_PRELOAD_RESET;
      st.count <= hmc_pkg::TIMER_COUNT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign run_o = st.run;
  assign count_o = st.count;

  property p_halt_holds;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!st.run && !cfg_wr_i) |=> (st.count == $past(st.count));
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("halted timer moved");

  property p_step_down;
    @(posedge clk_i) disable iff (!reset_n_i)
      (st.run && tick_i && !cfg_wr_i && st.count != 16'h0000)
        |=> (st.count == $past(st.count) - 16'h0001);
  endproperty
  a_step_down: assert property (p_step_down) else $error("timer did not step down");

  property p_stop_preset;
    @(posedge clk_i) disable iff (!reset_n_i)
      (cfg_wr_i && st.run && !cfg_run_i) |=> (!st.run && st.preload == 16'hFFFF);
  endproperty
  a_stop_preset: assert property (p_stop_preset) else $error("preload not preset");

endmodule

`default_nettype wire

/* hmc_bank.sv */
// Host misc register bank: timer view, half-order control, free tick and discard counters.
`default_nettype none

module hmc_bank (
  input wire logic clk_i, // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic bus16_i, // Pin: high when host bus is 16 bits wide.
  input wire logic cs_n_i, // Pin: chip select, active low.
  input wire logic rd_n_i, // Pin: read strobe, active low.
  input wire logic wr_n_i, // Pin: write strobe, active low.
  input wire logic [7:0] addr_i, // Pin: byte address, bit 1 picks the half.
  input wire logic [31:0] data_i, // Pin: host write data.
  output logic [31:0] data_o, // Host read data, registered.
  output logic data_oe_n_o, // Low while the bank drives the data pins.
  input wire logic tmr_cfg_wr_i, // Pulse: timer configuration written.
  input wire logic tmr_run_i, // Timer run bit of that write.
  input wire logic [15:0] tmr_preload_i, // Timer preload of that write.
  input wire logic tmr_tick_i, // Pulse: timer tick.
  input wire logic frame_drop_i, // Pulse: a received frame was discarded.
  output logic discard_mid_o, // Pulse: discard counter crossed its midpoint.
  input wire logic [31:0] tx_word_i, // Word from transmit buffer.
  input wire logic tx_word_valid_i, // Pulse: transmit word offered.
  output logic tx_word_ready_o, // High when a transmit word can be taken.
  output logic [15:0] tx_half_o, // Half-word toward the network, registered.
  output logic tx_half_valid_o, // Pulse: tx_half_o valid.
  input wire logic [15:0] rx_half_i, // Half-word from the network.
  input wire logic rx_half_valid_i, // Pulse: rx_half_i valid.
  output logic [31:0] rx_word_o, // Assembled receive word, registered.
  output logic rx_word_valid_o // Pulse: rx_word_o valid.
);

  hmc_pkg::hmc_state_t st;
  hmc_pkg::hmc_state_t next_st;
  hmc_pkg::hmc_pins_t pins;
  logic [15:0] timer_present_count;
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_start;
  logic pick_high;
  logic [7:0] reg_off;
  logic [31:0] word;

  hmc_gp_timer u_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .cfg_wr_i(tmr_cfg_wr_i),
    .cfg_run_i(tmr_run_i),
    .cfg_preload_i(tmr_preload_i),
    .tick_i(tmr_tick_i),
    .run_o(),
    .count_o(timer_present_count)
  );

  // Address and data ride the same two stages as the strobes, so they line up with the
  // strobe edge the bank acts on. The host must hold them until the strobe is released.
  assign pins = '{bus16: bus16_i, cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
                  addr: addr_i, data: data_i};
  assign rd_act = !st.sync2.cs_n && !st.sync2.rd_n;
  assign wr_act = !st.sync2.cs_n && !st.sync2.wr_n;
  assign rd_start = rd_act && !st.rd_prev;
  assign wr_start = wr_act && !st.wr_prev;
  assign reg_off = {st.sync2.addr[7:2], 2'b00};

  ////////////////////////////////////////////////////////////////////////////////
  // Half selection and register read mux.

  always_comb begin
    if (st.half_order == hmc_pkg::HALF_ORDER_SWAPPED) begin
      pick_high = !st.sync2.addr[1];
    end else begin
      pick_high = st.sync2.addr[1];
    end
  end

  always_comb begin
    if (reg_off == hmc_pkg::OFF_TIMER_PRESENT_COUNT) begin
      word = {16'h0000, timer_present_count};
    end else if (reg_off == hmc_pkg::OFF_HOST_HALF_ORDER_CONTROL) begin
      word = st.half_order;
    end else if (reg_off == hmc_pkg::OFF_FREE_TICK_COUNT) begin
      word = (st.sync2.bus16 && st.latch_valid) ? st.free_latch : st.free_tick;
    end else if (reg_off == hmc_pkg::OFF_DISCARDED_FRAME_TALLY) begin
      word = st.discard;
    end else begin
      word = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_st = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.rd_prev = rd_act;
    next_st.wr_prev = wr_act;
    next_st.free_tick = st.free_tick + 32'h0000_0001;
    next_st.discard_mid = 1'b0;
    next_st.tx_half_valid = 1'b0;
    next_st.rx_word_valid = 1'b0;

    if (rd_start) begin
      if (st.sync2.bus16) begin
        next_st.rd_data = {16'h0000, pick_high ? word[31:16] : word[15:0]};
      end else begin
        next_st.rd_data = word;
      end
      // The latch lives for one pair of half reads; the second half consumes it.
      if (reg_off == hmc_pkg::OFF_FREE_TICK_COUNT && st.sync2.bus16) begin
        next_st.latch_valid = !st.latch_valid;
        if (!st.latch_valid) begin
          next_st.free_latch = st.free_tick;
        end
      end
    end

    // A discard arriving in the clearing cycle is kept as a count of one.
    if (rd_start && reg_off == hmc_pkg::OFF_DISCARDED_FRAME_TALLY) begin
      next_st.discard = frame_drop_i ? 32'h0000_0001 : hmc_pkg::DISCARD_RESET;
    end else if (frame_drop_i) begin
      next_st.discard = st.discard + 32'h0000_0001;
      next_st.discard_mid = (st.discard == hmc_pkg::DISCARD_BELOW_MID);
    end

    if (wr_start && reg_off == hmc_pkg::OFF_HOST_HALF_ORDER_CONTROL) begin
      if (!st.sync2.bus16) begin
        next_st.half_order = st.sync2.data;
      end else if (pick_high) begin
        next_st.half_order[31:16] = st.sync2.data[15:0];
      end else begin
        next_st.half_order[15:0] = st.sync2.data[15:0];
      end
    end

    // Transmit: low half leaves first, high half on the following cycle.
    if (st.tx_pend) begin
      next_st.tx_half = st.tx_high;
      next_st.tx_half_valid = 1'b1;
      next_st.tx_pend = 1'b0;
    end else if (tx_word_valid_i) begin
      next_st.tx_half = tx_word_i[15:0];
      next_st.tx_high = tx_word_i[31:16];
      next_st.tx_half_valid = 1'b1;
      next_st.tx_pend = 1'b1;
    end

    // Receive: first half of a pair is the low half.
    if (rx_half_valid_i) begin
      if (st.rx_have_low) begin
        next_st.rx_word = {rx_half_i, st.rx_low};
        next_st.rx_word_valid = 1'b1;
        next_st.rx_have_low = 1'b0;
      end else begin
        next_st.rx_low = rx_half_i;
        next_st.rx_have_low = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st <= '0;
      st.sync1 <= hmc_pkg::PINS_IDLE;
      st.sync2 <= hmc_pkg::PINS_IDLE;
      st.half_order <= hmc_pkg::HALF_ORDER_RESET;
      st.free_tick <= hmc_pkg::FREE_TICK_RESET;
      st.discard <= hmc_pkg::DISCARD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign data_o = st.rd_data;
  assign data_oe_n_o = !rd_act;
  assign discard_mid_o = st.discard_mid;
  assign tx_word_ready_o = !st.tx_pend;
  assign tx_half_o = st.tx_half;
  assign tx_half_valid_o = st.tx_half_valid;
  assign rx_word_o = st.rx_word;
  assign rx_word_valid_o = st.rx_word_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_free_counts;
    @(posedge clk_i) disable iff (!reset_n_i)
      $past(reset_n_i) |-> (st.free_tick == $past(st.free_tick) + 32'h0000_0001);
  endproperty
  a_free_counts: assert property (p_free_counts) else $error("free counter missed a step");

  property p_free_wraps;
    @(posedge clk_i) disable iff (!reset_n_i)
      (st.free_tick == 32'hFFFF_FFFF) |=> (st.free_tick == 32'h0000_0000);
  endproperty
  a_free_wraps: assert property (p_free_wraps) else $error("free counter did not wrap");

  property p_read_clears;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_start && reg_off == hmc_pkg::OFF_DISCARDED_FRAME_TALLY && !frame_drop_i)
        |=> (st.discard == 32'h0000_0000);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("discard not cleared on read");

  property p_drop_counts;
    @(posedge clk_i) disable iff (!reset_n_i)
      (frame_drop_i && !rd_start) |=> (st.discard == $past(st.discard) + 32'h0000_0001);
  endproperty
  a_drop_counts: assert property (p_drop_counts) else $error("discard not counted");

  property p_mid_event;
    @(posedge clk_i) disable iff (!reset_n_i)
      st.discard_mid |-> (st.discard == 32'h8000_0000 && $past(st.discard) == 32'h7FFF_FFFF);
  endproperty
  a_mid_event: assert property (p_mid_event) else $error("midpoint event misplaced");

  property p_wide_read;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_start && !st.sync2.bus16 && reg_off == hmc_pkg::OFF_HOST_HALF_ORDER_CONTROL)
        |=> (st.rd_data == $past(st.half_order));
  endproperty
  a_wide_read: assert property (p_wide_read) else $error("32-bit read mapped wrongly");

  property p_half_select;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_start && st.sync2.bus16 && reg_off == hmc_pkg::OFF_HOST_HALF_ORDER_CONTROL)
        |=> (st.rd_data[15:0] == (($past(st.half_order) == 32'hFFFF_FFFF) ^ $past(st.sync2.addr[1])
              ? $past(st.half_order[31:16]) : $past(st.half_order[15:0])));
  endproperty
  a_half_select: assert property (p_half_select) else $error("16-bit half select wrong");

  property p_tx_order;
    @(posedge clk_i) disable iff (!reset_n_i)
      (tx_word_valid_i && !st.tx_pend)
        |=> (tx_half_valid_o && tx_half_o == $past(tx_word_i[15:0]))
          ##1 (tx_half_valid_o && tx_half_o == $past(tx_word_i[31:16], 2));
  endproperty
  a_tx_order: assert property (p_tx_order) else $error("transmit halves out of order");

  property p_latch_pair;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_start && st.sync2.bus16 && reg_off == hmc_pkg::OFF_FREE_TICK_COUNT && !st.latch_valid)
        |=> (st.latch_valid && st.free_latch == $past(st.free_tick));
  endproperty
  a_latch_pair: assert property (p_latch_pair) else $error("free count not latched");

endmodule

`default_nettype wire

/* hmc_host_model.sv */
// Host processor model that drives the bank's parallel bus pins.
`default_nettype none

module hmc_host_model (
  input wire logic clk_i, // System clock.
  output logic bus16_o, // Bus width strap.
  output logic cs_n_o, // Chip select, active low.
  output logic rd_n_o, // Read strobe, active low.
  output logic wr_n_o, // Write strobe, active low.
  output logic [7:0] addr_o, // Byte address.
  output logic [31:0] data_o // Write data.
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    bus16_o = 1'b0;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 8'h00;
    data_o = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobes are held long enough to cross the pin synchroniser. Released lines
  // show the inverse of their last value, so a late sample cannot look right.
  // Every access lasts exactly 12 cycles, which lets the bench time the counter.
  task automatic acc(input logic wr, input logic b16, input logic [7:0] a,
                     input logic [31:0] d);
    @(negedge clk_i);
    bus16_o = b16;
    addr_o = a;
    data_o = d;
    cs_n_o = 1'b0;
    rd_n_o = wr;
    wr_n_o = !wr;
    repeat (6) @(negedge clk_i);
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    repeat (3) @(negedge clk_i);
    addr_o = ~a;
    data_o = ~d;
    repeat (2) @(negedge clk_i);
  endtask
endmodule

`default_nettype wire

/* hmc_bank_bench.sv */
// Self-checking bench for the host misc register bank.
`default_nettype none

module hmc_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic b16, cs_n, rd_n, wr_n, oe_n, cfg_wr, run, tick, drop, mid;
  logic txv, txr, txhv, rxhv, rxwv;
  logic rd_due = 1'b0;
  logic [7:0] addr;
  logic [15:0] pre, txh, rxh;
  logic [31:0] wd, rdata, txw, rxw, last_rd, free_a, e, m, w;
  logic [31:0] exp_rd[$], msk_rd[$], exp_tx[$], exp_rx[$];
  logic oe_prev = 1'b1;
  int num_errors = 0;
  int cmp_count = 0;
  int n;

  always #50 clk = ~clk;

  hmc_host_model host (.clk_i(clk), .bus16_o(b16), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .addr_o(addr), .data_o(wd));

  hmc_bank DUT (.clk_i(clk), .reset_n_i(rst_n), .bus16_i(b16), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .data_i(wd), .data_o(rdata),
    .data_oe_n_o(oe_n), .tmr_cfg_wr_i(cfg_wr), .tmr_run_i(run), .tmr_preload_i(pre),
    .tmr_tick_i(tick), .frame_drop_i(drop), .discard_mid_o(mid), .tx_word_i(txw),
    .tx_word_valid_i(txv), .tx_word_ready_o(txr), .tx_half_o(txh),
    .tx_half_valid_o(txhv), .rx_half_i(rxh), .rx_half_valid_i(rxhv),
    .rx_word_o(rxw), .rx_word_valid_o(rxwv));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // An empty queue yields unknowns, so an unexpected result mismatches unless it is a read of all ones.
  function automatic logic [31:0] nxt(ref logic [31:0] q[$]);
    if (q.size() == 0) return 32'hxxxx_xxxx;
    return q.pop_front();
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read data settles one cycle after the bank starts driving the pins.
  always @(negedge clk) begin
    if (rd_due) begin
      e = nxt(exp_rd);
      m = nxt(msk_rd);
      last_rd = rdata;
      chk("data_o", e & m, rdata & m);
    end
    rd_due = rst_n && oe_prev && (oe_n === 1'b0);
    oe_prev = oe_n;
    if (txhv === 1'b1) chk("tx_half_o", nxt(exp_tx), {16'h0000, txh});
    if (rxwv === 1'b1) chk("rx_word_o", nxt(exp_rx), rxw);
    if (mid === 1'b1) chk("discard_mid_o", 32'h0000_0000, 32'h0000_0001);
  end

  task automatic rd(input logic b, input logic [7:0] a, input logic [31:0] ex,
                    input logic [31:0] mk = 32'hFFFF_FFFF);
    exp_rd.push_back(ex);
    msk_rd.push_back(mk);
    host.acc(1'b0, b, a, 32'h0000_0000);
  endtask

  task automatic pulse(ref logic s, input int k);
    repeat (k) begin
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
    end
  endtask

  task automatic cfg(input logic r, input logic [15:0] p);
    @(negedge clk);
    cfg_wr = 1'b1;
    run = r;
    pre = p;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {cfg_wr, run, tick, drop, txv, rxhv} = 6'h00;
    pre = 16'h0000;
    txw = 32'h0000_0000;
    rxh = 16'h0000;
    void'($urandom(32'hf8ad));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (hmc_pkg::FREE_CLEAR_CYCLES) @(negedge clk);
    rd(1'b0, 8'h90, 32'h0000_FFFF);
    rd(1'b0, 8'h98, 32'h0000_0000);
    rd(1'b0, 8'hA0, 32'h0000_0000);
    rd(1'b0, 8'h94, 32'h0000_0000);
    host.acc(1'b1, 1'b0, 8'h90, 32'h1234_5678);
    rd(1'b0, 8'h90, 32'h0000_FFFF);
    end_test("reset");
    rd(1'b1, 8'h92, 32'h0000_0000);
    rd(1'b1, 8'h90, 32'h0000_FFFF);
    host.acc(1'b1, 1'b0, 8'h98, 32'hFFFF_FFFF);
    rd(1'b0, 8'h98, 32'hFFFF_FFFF);
    rd(1'b1, 8'h92, 32'h0000_FFFF);
    rd(1'b1, 8'h90, 32'h0000_0000);
    rd(1'b0, 8'h90, 32'h0000_FFFF);
    host.acc(1'b1, 1'b0, 8'h98, 32'hFFFF_FFFE);
    rd(1'b1, 8'h92, 32'h0000_0000);
    end_test("half order");
    rd(1'b0, 8'h9C, 32'h0000_0000, 32'h0000_0000);
    free_a = last_rd;
    rd(1'b0, 8'h9C, 32'h0000_0000, 32'h0000_0000);
    chk("free step", free_a + 32'd12, last_rd);
    rd(1'b1, 8'h9C, 32'h0000_0000, 32'hFFFF_0000);
    free_a = last_rd;
    rd(1'b1, 8'h9C, 32'h0000_0000, 32'hFFFF_0000);
    chk("free latch", free_a, last_rd);
    rd(1'b1, 8'h9C, 32'h0000_0000, 32'hFFFF_0000);
    chk("free relatch", {16'h0000, free_a[15:0] + 16'd24}, last_rd);
    end_test("free counter");
    pulse(drop, 3);
    rd(1'b0, 8'hA0, 32'h0000_0003);
    rd(1'b0, 8'hA0, 32'h0000_0000);
    end_test("discard");
    cfg(1'b1, 16'h0005);
    pulse(tick, 3);
    rd(1'b0, 8'h90, 32'h0000_0002);
    cfg(1'b0, 16'h0000);
    pulse(tick, 2);
    rd(1'b0, 8'h90, 32'h0000_0002);
    end_test("timer");
    for (int i = 0; i < 4; i++) begin
      w = $urandom();
      exp_tx.push_back({16'h0000, w[15:0]});
      exp_tx.push_back({16'h0000, w[31:16]});
      n = 0;
      while (txr !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      if (n == 20) begin
        num_errors++;
        $display("Error tx_word_ready_o expected 1 seen %b", txr);
        finish_test();
      end
      txw = w;
      txv = 1'b1;
      @(negedge clk);
      txv = 1'b0;
      txw = ~w;
      w = $urandom();
      exp_rx.push_back(w);
      rxh = w[15:0];
      rxhv = 1'b1;
      @(negedge clk);
      rxh = w[31:16];
      @(negedge clk);
      rxhv = 1'b0;
      rxh = ~w[31:16];
    end
    repeat (10) @(negedge clk);
    end_test("data path");
    chk("pending", 32'h0000_0000, exp_rd.size() + exp_tx.size() + exp_rx.size());
    finish_test();
  end
endmodule

`default_nettype wire
